// [rtl/sdm_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

module sdm_ctrl #(
  parameter int                          P_CLK_HZ   = sdm_pkg::CLK_HZ,
  parameter logic [sdm_pkg::WAKE_W-1:0]  P_WAKE_CYC = sdm_pkg::WAKE_CYC,
  parameter logic [sdm_pkg::IDLE_W-1:0]  P_IDLE_CYC = sdm_pkg::IDLE_CYC
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire sdm_pkg::sdm_cfg_s i_cfg,
  input  wire logic              i_sleep_pin_b,
  input  wire logic              i_diag_rxd,
  input  wire logic [7:0]        i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  output logic                   o_diag_txd,
  output logic [7:0]             o_rx_data,
  output logic                   o_rx_valid,
  output logic                   o_cmd_mode,
  output logic                   o_baud_locked,
  output logic                   o_sleep,
  output logic                   o_payload_ready
);

  logic [1:0]                    pins_s;
  logic                          sleep_pin_s;
  logic                          rxd_s;
  logic                          sleep_req;
  logic                          asleep;
  sdm_pkg::sdm_sleep_e           sleep_st;
  logic [sdm_pkg::WAKE_W-1:0]    wake_cnt;

  sdm_pkg::sdm_rx_e              rx_state;
  logic [sdm_pkg::PER_W-1:0]     rx_cnt;
  logic [sdm_pkg::PER_W-1:0]     rx_lim;
  logic [sdm_pkg::PER_W-1:0]     rx_per;
  logic [sdm_pkg::PER_W-1:0]     sel_per;
  logic [2:0]                    rx_bit;
  logic [7:0]                    rx_shift;
  logic                          stop_end;
  logic                          char_ok;
  logic                          frame_err;

  logic                          esc_seen;
  logic                          locked;
  logic                          started;
  logic                          prompt_pend;
  logic                          entry_done;
  logic                          timeout;
  sdm_pkg::sdm_port_e            port_mode;
  logic [sdm_pkg::IDLE_W-1:0]    idle_cnt;

  sdm_pkg::sdm_tx_e              tx_state;
  logic [sdm_pkg::PER_W-1:0]     tx_cnt;
  logic [2:0]                    tx_bit;
  logic [7:0]                    tx_shift;
  logic                          tx_go_prompt;
  logic                          tx_go_user;
  logic                          tx_bit_end;

  // both pins idle high, so the reset value keeps the port quiet
  sdm_sync #(
    .W       (2),
    .RST_VAL (sdm_pkg::PIN_IDLE)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_d       ({i_sleep_pin_b, i_diag_rxd}),
    .o_q       (pins_s)
  );

  assign sleep_pin_s = pins_s[1];
  assign rxd_s       = pins_s[0];

  // sleep_on is the command-switched setting held upstream
  assign sleep_req = !sleep_pin_s && i_cfg.remote_unit && i_cfg.sleep_on;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_st <= sdm_pkg::SL_AWAKE;
      wake_cnt <= '0;
    end else begin
      case (sleep_st)
        sdm_pkg::SL_AWAKE: begin
          wake_cnt <= '0;
          if (sleep_req) begin
            sleep_st <= sdm_pkg::SL_ASLEEP;
          end
        end
        sdm_pkg::SL_ASLEEP: begin
          wake_cnt <= '0;
          if (!sleep_req) begin
            sleep_st <= sdm_pkg::SL_WAKING;
          end
        end
        sdm_pkg::SL_WAKING: begin
          if (sleep_req) begin
            sleep_st <= sdm_pkg::SL_ASLEEP;
          end else if (wake_cnt == P_WAKE_CYC - 1'b1) begin
            sleep_st <= sdm_pkg::SL_AWAKE;
          end else begin
            wake_cnt <= wake_cnt + 1'b1;
          end
        end
        default: sleep_st <= sdm_pkg::SL_AWAKE;
      endcase
    end
  end

  assign asleep          = (sleep_st == sdm_pkg::SL_ASLEEP);
  assign o_sleep         = asleep;
  assign o_payload_ready = (sleep_st == sdm_pkg::SL_AWAKE);

  // escape and enter both start with a one-bit low run, which gives the rate
  always_comb begin
    sel_per = sdm_pkg::bit_per(P_CLK_HZ, 0);
    for (int i = 0; i < sdm_pkg::N_BAUD - 1; i++) begin
      if (rx_cnt < sdm_pkg::bit_thresh(P_CLK_HZ, i)) begin
        sel_per = sdm_pkg::bit_per(P_CLK_HZ, i + 1);
      end
    end
  end

  assign stop_end  = (rx_state == sdm_pkg::RX_STOP) && (rx_cnt == rx_per - 1'b1);
  assign char_ok   = stop_end && rxd_s;
  assign frame_err = stop_end && !rxd_s;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state <= sdm_pkg::RX_IDLE;
      rx_cnt   <= '0;
      rx_lim   <= '0;
      rx_per   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
    end else if (asleep) begin
      rx_state <= sdm_pkg::RX_IDLE;
      rx_cnt   <= '0;
    end else begin
      case (rx_state)
        sdm_pkg::RX_IDLE: begin
          rx_cnt <= '0;
          rx_bit <= '0;
          if (!rxd_s) begin
            rx_state <= locked ? sdm_pkg::RX_START : sdm_pkg::RX_MEAS;
          end
        end
        sdm_pkg::RX_MEAS: begin
          if (rxd_s) begin
            rx_per   <= sel_per;
            rx_lim   <= sel_per >> 1;
            rx_cnt   <= '0;
            rx_state <= sdm_pkg::RX_DATA;
          end else if (rx_cnt != sdm_pkg::MEAS_MAX) begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        sdm_pkg::RX_START: begin
          if (rx_cnt == (rx_per >> 1) - 1'b1) begin
            rx_cnt   <= '0;
            rx_lim   <= rx_per;
            rx_state <= rxd_s ? sdm_pkg::RX_IDLE : sdm_pkg::RX_DATA;
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        sdm_pkg::RX_DATA: begin
          if (rx_cnt == rx_lim - 1'b1) begin
            rx_cnt   <= '0;
            rx_lim   <= rx_per;
            rx_shift <= {rxd_s, rx_shift[7:1]};
            if (rx_bit == sdm_pkg::BIT_LAST) begin
              rx_state <= sdm_pkg::RX_STOP;
            end else begin
              rx_bit <= rx_bit + 1'b1;
            end
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        sdm_pkg::RX_STOP: begin
          if (stop_end) begin
            rx_state <= sdm_pkg::RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + 1'b1;
          end
        end
        default: rx_state <= sdm_pkg::RX_IDLE;
      endcase
    end
  end

  assign entry_done = char_ok && esc_seen && (rx_shift == sdm_pkg::CHAR_ENTER);
  assign timeout    = (port_mode == sdm_pkg::PM_CMD) && !char_ok &&
                      (idle_cnt == P_IDLE_CYC - 1'b1);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      esc_seen <= 1'b0;
      locked   <= 1'b0;
    end else begin
      if (char_ok) begin
        // further enters keep the sequence armed
        esc_seen <= (rx_shift == sdm_pkg::CHAR_ESC) ||
                    (esc_seen && rx_shift == sdm_pkg::CHAR_ENTER);
      end
      if (entry_done) begin
        locked <= 1'b1;
      end else if (frame_err) begin
        // a wrong rate shows as a bad stop bit, so hunt again
        locked <= 1'b0;
      end
    end
  end

  // the mode setting is a port, so it is taken on the first edge after reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      started   <= 1'b0;
      port_mode <= sdm_pkg::PM_CMD;
    end else if (!started) begin
      started   <= 1'b1;
      port_mode <= i_cfg.diag_link_on ? sdm_pkg::PM_PROTO : sdm_pkg::PM_CMD;
    end else if (entry_done) begin
      port_mode <= sdm_pkg::PM_CMD;
    end else if (!i_cfg.diag_link_on) begin
      port_mode <= sdm_pkg::PM_CMD;
    end else if (timeout) begin
      port_mode <= sdm_pkg::PM_PROTO;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idle_cnt <= '0;
    end else if (port_mode != sdm_pkg::PM_CMD || char_ok) begin
      idle_cnt <= '0;
    end else if (idle_cnt != P_IDLE_CYC - 1'b1) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= '0;
    end else begin
      o_rx_valid <= char_ok && locked;
      if (char_ok) begin
        o_rx_data <= rx_shift;
      end
    end
  end

  // set wins over the load that clears it
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prompt_pend <= 1'b0;
    end else if (entry_done) begin
      prompt_pend <= 1'b1;
    end else if (tx_go_prompt) begin
      prompt_pend <= 1'b0;
    end
  end

  assign tx_go_prompt = (tx_state == sdm_pkg::TX_IDLE) && prompt_pend && !asleep;
  assign o_tx_ready   = (tx_state == sdm_pkg::TX_IDLE) && !prompt_pend && locked && !asleep;
  assign tx_go_user   = o_tx_ready && i_tx_valid;
  assign tx_bit_end   = (tx_cnt == rx_per - 1'b1);

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_state   <= sdm_pkg::TX_IDLE;
      tx_cnt     <= '0;
      tx_bit     <= '0;
      tx_shift   <= '0;
      o_diag_txd <= sdm_pkg::PIN_IDLE;
    end else if (asleep) begin
      tx_state   <= sdm_pkg::TX_IDLE;
      o_diag_txd <= sdm_pkg::PIN_IDLE;
    end else begin
      case (tx_state)
        sdm_pkg::TX_IDLE: begin
          tx_cnt     <= '0;
          tx_bit     <= '0;
          o_diag_txd <= sdm_pkg::PIN_IDLE;
          if (tx_go_prompt || tx_go_user) begin
            tx_shift   <= tx_go_prompt ? sdm_pkg::CHAR_PROMPT : i_tx_data;
            o_diag_txd <= 1'b0;
            tx_state   <= sdm_pkg::TX_START;
          end
        end
        sdm_pkg::TX_START: begin
          tx_cnt <= tx_bit_end ? '0 : tx_cnt + 1'b1;
          if (tx_bit_end) begin
            o_diag_txd <= tx_shift[0];
            tx_shift   <= tx_shift >> 1;
            tx_state   <= sdm_pkg::TX_DATA;
          end
        end
        sdm_pkg::TX_DATA: begin
          tx_cnt <= tx_bit_end ? '0 : tx_cnt + 1'b1;
          if (tx_bit_end) begin
            if (tx_bit == sdm_pkg::BIT_LAST) begin
              tx_bit     <= '0;
              o_diag_txd <= 1'b1;
              tx_state   <= sdm_pkg::TX_STOP;
            end else begin
              tx_bit     <= tx_bit + 1'b1;
              o_diag_txd <= tx_shift[0];
              tx_shift   <= tx_shift >> 1;
            end
          end
        end
        sdm_pkg::TX_STOP: begin
          tx_cnt <= tx_bit_end ? '0 : tx_cnt + 1'b1;
          if (tx_bit_end) begin
            if (tx_bit == sdm_pkg::STOP_LAST) begin
              tx_state <= sdm_pkg::TX_IDLE;
            end else begin
              tx_bit <= tx_bit + 1'b1;
            end
          end
        end
        default: tx_state <= sdm_pkg::TX_IDLE;
      endcase
    end
  end

  assign o_cmd_mode    = (port_mode == sdm_pkg::PM_CMD);
  assign o_baud_locked = locked;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sleep_remote_a: assert property (!i_cfg.remote_unit |=> !o_sleep)
    else $error("sleep held without remote configuration");
  sleep_entry_a: assert property (sleep_st == sdm_pkg::SL_AWAKE && sleep_req |=> o_sleep ##1 o_sleep || !sleep_req)
    else $error("sleep request not honoured");
  sleep_hold_a: assert property (o_sleep && sleep_req |=> o_sleep)
    else $error("sleep left while input low");
  wake_bound_a: assert property (sleep_st == sdm_pkg::SL_WAKING |-> wake_cnt < P_WAKE_CYC)
    else $error("wake delay overran");
  wake_ready_a: assert property (sleep_st == sdm_pkg::SL_WAKING && !sleep_req && wake_cnt == P_WAKE_CYC - 1'b1 |=> o_payload_ready)
    else $error("not ready at end of wake delay");
  sleep_ignored_a: assert property (!i_cfg.sleep_on |=> !o_sleep)
    else $error("sleep entered while disabled");
  tx_frame_a: assert property ($rose(tx_state == sdm_pkg::TX_STOP) |-> o_diag_txd && $past(tx_state) == sdm_pkg::TX_DATA)
    else $error("stop bit not high after data");
  rate_pick_a: assert property (rx_state == sdm_pkg::RX_MEAS && rxd_s && !asleep |=> rx_per == $past(sel_per))
    else $error("measured rate not taken");
  prompt_sent_a: assert property (entry_done && !asleep && tx_state == sdm_pkg::TX_IDLE |=> prompt_pend ##1 tx_state == sdm_pkg::TX_START)
    else $error("prompt not started after lock");
  start_mode_a: assert property (!started && i_cfg.diag_link_on |=> !o_cmd_mode)
    else $error("did not start in protocol mode");
  entry_cmd_a: assert property (started && entry_done |=> o_cmd_mode && o_baud_locked)
    else $error("entry sequence did not reach command mode");
  idle_revert_a: assert property (started && timeout && i_cfg.diag_link_on |=> !o_cmd_mode)
    else $error("inactivity did not revert to protocol mode");

  sleep_seen_c: cover property ($rose(o_sleep));
  wake_done_c: cover property (sleep_st == sdm_pkg::SL_WAKING ##1 o_payload_ready);
  entry_seen_c: cover property (!o_cmd_mode ##1 entry_done);
  revert_seen_c: cover property (timeout && i_cfg.diag_link_on);

endmodule

`default_nettype wire

// [rtl/sdm_pkg.sv]
package sdm_pkg;

  localparam int CLK_HZ        = 50_000_000;

  localparam int WAKE_TIME_MS  = 75;
  localparam int WAKE_W        = 22;
  // longest time, so the count rounds down
  localparam logic [WAKE_W-1:0] WAKE_CYC =
    WAKE_W'(longint'(WAKE_TIME_MS) * longint'(CLK_HZ) / 1000);

  localparam int IDLE_TIME_MIN = 5;
  localparam int IDLE_W        = 34;
  localparam logic [IDLE_W-1:0] IDLE_CYC =
    IDLE_W'(longint'(IDLE_TIME_MIN) * 60 * longint'(CLK_HZ));

  localparam int DATA_BITS     = 8;
  localparam int STOP_BITS     = 1;
  localparam logic [2:0] BIT_LAST  = 3'(DATA_BITS - 1);
  localparam logic [2:0] STOP_LAST = 3'(STOP_BITS - 1);

  localparam int PER_W         = 17;
  localparam logic [PER_W-1:0] MEAS_MAX = 17'h1FFFF;
  localparam int N_BAUD        = 8;
  localparam int BAUD_TAB [N_BAUD] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};

  localparam logic [7:0] CHAR_ESC    = 8'h1B;
  localparam logic [7:0] CHAR_ENTER  = 8'h0D;
  localparam logic [7:0] CHAR_PROMPT = 8'h3E;

  localparam logic       PIN_IDLE    = 1'b1;

  typedef struct packed {
    logic remote_unit;
    logic sleep_on;
    logic diag_link_on;
  } sdm_cfg_s;

  typedef enum logic [1:0] {SL_AWAKE, SL_ASLEEP, SL_WAKING} sdm_sleep_e;
  typedef enum logic [2:0] {RX_IDLE, RX_MEAS, RX_START, RX_DATA, RX_STOP} sdm_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sdm_tx_e;
  typedef enum logic {PM_PROTO, PM_CMD} sdm_port_e;

  function automatic logic [PER_W-1:0] bit_per(input int clk_hz, input int idx);
    return PER_W'(clk_hz / BAUD_TAB[idx]);
  endfunction

  // midpoint between neighbouring bit periods
  function automatic logic [PER_W-1:0] bit_thresh(input int clk_hz, input int idx);
    return PER_W'((clk_hz / BAUD_TAB[idx] + clk_hz / BAUD_TAB[idx+1]) / 2);
  endfunction

endpackage

// [rtl/sdm_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module sdm_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] stage1;

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= {W{RST_VAL}};
      o_q    <= {W{RST_VAL}};
    end else begin
      stage1 <= i_d;
      o_q    <= stage1;
    end
  end

endmodule

`default_nettype wire

// [verif/sdm_term_model.sv]
`timescale 1ns/1ns
`default_nettype none

module sdm_term_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_bit_per,
  input  wire logic        i_txd,
  output logic             o_rxd
);
  int         rx_cnt  = 0;
  logic [7:0] rx_byte = 8'h00;

  initial o_rxd = 1'b1;

  // start, 8 data lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk_sys);
      o_rxd <= fr[i];
      repeat (i_bit_per - 16'h0001) @(posedge i_clk_sys);
    end
  endtask

  // samples mid-bit; a bad stop bit is not counted, so the bench times out
  always begin
    @(negedge i_clk_sys);
    if (i_txd === 1'b0) begin
      repeat (i_bit_per / 16'h0002) @(negedge i_clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (i_bit_per) @(negedge i_clk_sys);
        rx_byte[i] = i_txd;
      end
      repeat (i_bit_per) @(negedge i_clk_sys);
      if (i_txd === 1'b1) rx_cnt++;
    end
  end
endmodule

`default_nettype wire

// [verif/sleep_and_diag_port_mode_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module sleep_and_diag_port_mode_ctrl_tb_top;
  localparam int                         CLK  = 32'h0011_9400;
  localparam logic [sdm_pkg::WAKE_W-1:0] WAKE = 22'h000014;
  localparam logic [sdm_pkg::IDLE_W-1:0] IDLE = 34'h0_0000_3A98;

  logic              clk;
  logic              rst_b;
  sdm_pkg::sdm_cfg_s cfg;
  logic              pin_b;
  logic              rxd;
  logic [7:0]        tx_data;
  logic              tx_valid;
  logic              tx_ready;
  logic              txd;
  logic [7:0]        rx_data;
  logic              rx_valid;
  logic              cmd_mode;
  logic              locked;
  logic              sleep;
  logic              pay_rdy;
  logic [15:0]       per;
  int                bad_count = 0;
  int                checked   = 0;
  integer            seed      = 32'h7F3A;
  logic [7:0]        rx_q[$];
  logic              lk_exp = 1'b0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  sdm_ctrl #(
    .P_CLK_HZ   (CLK),
    .P_WAKE_CYC (WAKE),
    .P_IDLE_CYC (IDLE)
  ) dut_u (
    .i_clk_sys       (clk),
    .i_rst_b         (rst_b),
    .i_cfg           (cfg),
    .i_sleep_pin_b   (pin_b),
    .i_diag_rxd      (rxd),
    .i_tx_data       (tx_data),
    .i_tx_valid      (tx_valid),
    .o_tx_ready      (tx_ready),
    .o_diag_txd      (txd),
    .o_rx_data       (rx_data),
    .o_rx_valid      (rx_valid),
    .o_cmd_mode      (cmd_mode),
    .o_baud_locked   (locked),
    .o_sleep         (sleep),
    .o_payload_ready (pay_rdy)
  );

  sdm_term_model term_u (
    .i_clk_sys (clk),
    .i_bit_per (per),
    .i_txd     (txd),
    .o_rxd     (rxd)
  );

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    bad_count++;
    $display("ERROR t=%0t %s", $time, m);
    end_of_test;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // bytes the terminal sends while locked must come out in order
  always @(negedge clk) begin
    if (rx_valid === 1'b1 && rx_q.size() > 0) begin
      chk(rx_data, rx_q.pop_front(), "rx byte");
    end else if (rx_valid === 1'b1) begin
      // unlocked characters must never reach the output
      checked++;
      bad_count++;
      $display("ERROR t=%0t unexpected rx byte %h", $time, rx_data);
    end
  end

  task automatic wait_term(input int n0, input logic [7:0] exp);
    int k;
    k = 0;
    while (term_u.rx_cnt == n0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      fail("no byte at terminal");
    end else begin
      chk(term_u.rx_byte, exp, "terminal byte");
    end
  endtask

  task automatic dev_send(input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    tx_data  <= d;
    tx_valid <= 1'b1;
    @(negedge clk);
    while (tx_ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2000) fail("tx never ready");
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  task automatic do_reset(input logic dl);
    lk_exp = 1'b0;
    @(posedge clk);
    cfg   <= '{remote_unit: 1'b1, sleep_on: 1'b1, diag_link_on: dl};
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(8'(cmd_mode), 8'(!dl), "mode after reset");
    chk(8'(locked), 8'h00, "lock after reset");
  endtask

  task automatic enter_cmd;
    int n0;
    n0 = term_u.rx_cnt;
    // once locked, the entry characters come out as data too
    if (lk_exp) begin
      rx_q.push_back(sdm_pkg::CHAR_ESC);
      rx_q.push_back(sdm_pkg::CHAR_ENTER);
    end
    term_u.send_byte(sdm_pkg::CHAR_ESC);
    term_u.send_byte(sdm_pkg::CHAR_ENTER);
    wait_term(n0, sdm_pkg::CHAR_PROMPT);
    @(negedge clk);
    chk(8'(cmd_mode), 8'h01, "command mode");
    chk(8'(locked), 8'h01, "rate locked");
    lk_exp = 1'b1;
  endtask

  initial begin
    int         k;
    int         n;
    logic [7:0] b;
    rst_b    = 1'b0;
    cfg      = '0;
    pin_b    = 1'b1;
    tx_data  = 8'h00;
    tx_valid = 1'b0;
    per      = 16'h03C0;
    do_reset(1'b0);
    // every rate from a fresh reset, so detection starts unlocked each time
    for (int r = 0; r < sdm_pkg::N_BAUD; r++) begin
      per <= 16'(CLK / sdm_pkg::BAUD_TAB[r]);
      do_reset(1'b1);
      enter_cmd;
    end
    // bit 7 set keeps random bytes clear of escape and enter
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed)) | 8'h80;
      n = term_u.rx_cnt;
      dev_send(~b);
      rx_q.push_back(b);
      term_u.send_byte(b);
      wait_term(n, ~b);
    end
    repeat (IDLE - 100) @(negedge clk);
    chk(8'(cmd_mode), 8'h01, "command mode held");
    k = 0;
    while (cmd_mode !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) fail("no idle revert");
    chk(8'(cmd_mode), 8'h00, "idle revert");
    enter_cmd;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      cfg   <= '{remote_unit: c[0], sleep_on: c[1], diag_link_on: 1'b1};
      pin_b <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(8'(sleep), 8'h00, "sleep before sync");
      repeat (40) @(negedge clk);
      chk(8'(sleep), 8'(c == 3), "sleep state");
      chk(8'(pay_rdy), 8'(c != 3), "ready while low");
      chk(8'(tx_ready), 8'(c != 3), "tx suspended");
      @(posedge clk);
      pin_b <= 1'b1;
      repeat (10) @(negedge clk);
      chk(8'(sleep), 8'h00, "awake after release");
      chk(8'(pay_rdy), 8'(c != 3), "wake delay");
      repeat (WAKE + 10) @(negedge clk);
      chk(8'(pay_rdy), 8'h01, "payload ready");
    end
    chk(8'(rx_q.size()), 8'h00, "rx bytes left");
    end_of_test;
  end
endmodule

`default_nettype wire
